/* File: sgel_pkg.sv */
// sgel_pkg: constants and types of the gather error/status block
// assumes a 32-bit APB register port and a descriptor fetcher on the same clock
package sgel_pkg;
   ////////////////////////////////////////////////////////////////////////////
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          IRQ_W           = 4;
   // register byte offsets
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_STATUS      = 8'h04;
   localparam logic [7:0]  OFS_CURDESC     = 8'h08;
   localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h10;
   localparam logic [7:0]  OFS_IRQ_MASK    = 8'h14;
   // control fields
   localparam int          CTRL_RUN_BIT    = 0;
   localparam int          CTRL_SRST_BIT   = 2;
   // channel_status fields
   localparam int          STS_STOP_BIT    = 0;
   localparam int          STS_INT_BIT     = 8;
   localparam int          STS_SLV_BIT     = 9;
   localparam int          STS_DEC_BIT     = 10;
   localparam int          STS_RSVD_BIT    = 11;
   // error vector lanes
   localparam int          ERR_INT         = 0;
   localparam int          ERR_SLV         = 1;
   localparam int          ERR_DEC         = 2;
   // interrupt status lanes: stop event, then the three errors
   localparam int          IRQ_STOP        = 0;
   localparam int          IRQ_ERR_LO      = 1;
   // memory-mapped read response codes
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
   localparam logic [1:0]  RESP_DECERR     = 2'h3;
   localparam logic [31:0] CURDESC_RST     = 32'h0000_0000;

   typedef enum logic [1:0] {ST_HALTED, ST_RUN, ST_STOPPING} sgel_state_t;

   // one finished descriptor fetch
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic        complete;
      logic [1:0]  resp;
   } sgel_fetch_t;

   typedef struct packed {
      sgel_state_t       state;
      logic              run_stop;
      logic              stopped;
      logic [2:0]        err;
      logic [31:0]       curdesc;
      logic [IRQ_W-1:0]  irq_sts;
      logic [IRQ_W-1:0]  irq_mask;
      logic              irq;
      logic [DATA_W-1:0] prdata;
      logic              pslverr;
   } sgel_regs_t;
endpackage

/* File: sgel_status.sv */
// sgel_status: gather error flags, graceful halt and descriptor capture
// assumes APB master and descriptor fetcher on CLK_IN, engine idle from same clock
//////////////////////////////////////////////////////////////////////////////

// Contract
// - A fetched descriptor whose complete bit is already set sets error flag bit 8.
// - A slave error response on a descriptor read sets error flag bit 9.
// - A decode error on a descriptor address sets error flag bit 10.
// - Any such error clears run/stop, and stopped is set only after full shutdown.
// - On such an error the current descriptor pointer takes the failing address.
// - Several errors are all flagged but only the first address is captured.
// - Error flags stay set until a soft or hard reset, which alone clears them.
// - Without gather support the three error flags are held at zero.
// - Status bit 11 ignores writes and reads as zero.
// - Writes aimed at the error flags are ignored.
module sgel_status
   import sgel_pkg::*;
#(
   parameter int GATHER_SUPPORT_PRESENT = 1
) (
   input  wire logic                    CLK_IN,
   input  wire logic                    RSTN_IN,
   input  wire logic                    CE_IN,
   input  wire logic                    PSEL_IN,
   input  wire logic                    PENABLE_IN,
   input  wire logic                    PWRITE_IN,
   input  wire logic [sgel_pkg::ADDR_W-1:0] PADDR_IN,
   input  wire logic [sgel_pkg::DATA_W-1:0] PWDATA_IN,
   output logic      [sgel_pkg::DATA_W-1:0] PRDATA_OUT,
   output logic                         PREADY_OUT,
   output logic                         PSLVERR_OUT,
   input  wire sgel_pkg::sgel_fetch_t   FETCH_IN,
   input  wire logic                    ENGINE_IDLE_IN,
   output logic                         RUN_STOP_OUT,
   output logic                         ENGINE_STOPPED_OUT,
   output logic [2:0]                   ERR_FLAGS_OUT,
   output logic [31:0]                  CURDESC_OUT,
   output logic                         IRQ_OUT
);
   import sgel_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   generate
      if (GATHER_SUPPORT_PRESENT < 0 || GATHER_SUPPORT_PRESENT > 1) begin : g_chk
         $error("GATHER_SUPPORT_PRESENT must be 0 or 1");
      end
   endgenerate

   localparam logic SG = (GATHER_SUPPORT_PRESENT == 1);

   localparam sgel_regs_t RST = '{
      state:    ST_HALTED,
      run_stop: 1'b0,
      stopped:  1'b1,
      err:      3'h0,
      curdesc:  CURDESC_RST,
      irq_sts:  '0,
      irq_mask: '0,
      irq:      1'b0,
      prdata:   '0,
      pslverr:  1'b0
   };

   sgel_regs_t r_reg;
   sgel_regs_t r_next;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = hit(a, OFS_CTRL) | hit(a, OFS_STATUS) | hit(a, OFS_CURDESC) |
               hit(a, OFS_IRQ_STATUS) | hit(a, OFS_IRQ_MASK);
   endfunction

   function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a,
                                                   input sgel_regs_t r);
      logic [DATA_W-1:0] w;
      w = '0;
      if (hit(a, OFS_CTRL)) begin
         w[CTRL_RUN_BIT] = r.run_stop;
      end
      if (hit(a, OFS_STATUS)) begin
         w[STS_STOP_BIT] = r.stopped;
         w[STS_INT_BIT]  = r.err[ERR_INT];
         w[STS_SLV_BIT]  = r.err[ERR_SLV];
         w[STS_DEC_BIT]  = r.err[ERR_DEC];
         w[STS_RSVD_BIT] = 1'b0;
      end
      if (hit(a, OFS_CURDESC)) begin
         w = r.curdesc;
      end
      if (hit(a, OFS_IRQ_STATUS)) begin
         w[IRQ_W-1:0] = r.irq_sts;
      end
      if (hit(a, OFS_IRQ_MASK)) begin
         w[IRQ_W-1:0] = r.irq_mask;
      end
      read_word = w;
   endfunction

   //////////////////////////////////////////////////////////////////////////
   logic       setup;
   logic       access;
   logic       wr;
   logic       soft_req;
   logic [2:0] errs;
   logic       new_err;

   assign setup    = PSEL_IN & ~PENABLE_IN;
   assign access   = PSEL_IN & PENABLE_IN;
   assign wr       = access & PWRITE_IN;
   assign soft_req = wr & hit(PADDR_IN, OFS_CTRL) & PWDATA_IN[CTRL_SRST_BIT];

   always_comb begin
      errs          = '0;
      errs[ERR_INT] = FETCH_IN.valid & FETCH_IN.complete &
                      (FETCH_IN.resp == RESP_OKAY);
      errs[ERR_SLV] = FETCH_IN.valid & (FETCH_IN.resp == RESP_SLVERR);
      errs[ERR_DEC] = FETCH_IN.valid & (FETCH_IN.resp == RESP_DECERR);
      errs          = errs & {3{SG}};
   end

   assign new_err = |errs;

   always_comb begin
      r_next = r_reg;
      if (setup) begin
         r_next.prdata  = read_word(PADDR_IN, r_reg);
         r_next.pslverr = ~mapped(PADDR_IN);
      end
      // clear only bits actually returned, so a fresh event survives
      if (access && !PWRITE_IN && hit(PADDR_IN, OFS_IRQ_STATUS)) begin
         r_next.irq_sts = r_reg.irq_sts & ~r_reg.prdata[IRQ_W-1:0];
      end
      // status register writes fall through: flags and reserved bit read-only
      if (wr && hit(PADDR_IN, OFS_CTRL)) begin
         r_next.run_stop = PWDATA_IN[CTRL_RUN_BIT] & (r_reg.err == 3'h0);
      end
      if (wr && hit(PADDR_IN, OFS_CURDESC) && r_reg.state == ST_HALTED) begin
         r_next.curdesc = PWDATA_IN;
      end
      if (wr && hit(PADDR_IN, OFS_IRQ_MASK)) begin
         r_next.irq_mask = PWDATA_IN[IRQ_W-1:0];
      end
      if (new_err) begin
         r_next.err      = r_reg.err | errs;
         r_next.run_stop = 1'b0;
         if (r_reg.err == 3'h0) begin
            r_next.curdesc = FETCH_IN.addr;
         end
         r_next.irq_sts[IRQ_ERR_LO +: 3] = r_next.irq_sts[IRQ_ERR_LO +: 3] | errs;
      end
      case (r_reg.state)
         ST_HALTED: begin
            if (r_next.run_stop) begin
               r_next.state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!r_next.run_stop) begin
               r_next.state = ST_STOPPING;
            end
         end
         ST_STOPPING: begin
            if (ENGINE_IDLE_IN) begin
               r_next.state             = ST_HALTED;
               r_next.irq_sts[IRQ_STOP] = 1'b1;
            end
         end
         default: begin
            r_next.state = ST_HALTED;
         end
      endcase
      r_next.stopped = (r_next.state == ST_HALTED);
      r_next.irq     = |(r_next.irq_sts & r_next.irq_mask);
      if (soft_req) begin
         r_next = RST;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RSTN_IN) begin
         r_reg <= RST;
      end else if (CE_IN) begin
         r_reg <= r_next;
      end
   end

   assign PRDATA_OUT         = r_reg.prdata;
   assign PSLVERR_OUT        = r_reg.pslverr & PSEL_IN & PENABLE_IN;
   assign PREADY_OUT         = CE_IN;
   assign RUN_STOP_OUT       = r_reg.run_stop;
   assign ENGINE_STOPPED_OUT = r_reg.stopped;
   assign ERR_FLAGS_OUT      = r_reg.err;
   assign CURDESC_OUT        = r_reg.curdesc;
   assign IRQ_OUT            = r_reg.irq;

   //////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RSTN_IN);

   property p_int_err;
      CE_IN && errs[ERR_INT] && !soft_req |=> r_reg.err[ERR_INT];
   endproperty
   a_int_err: assert property (p_int_err) else $error("internal error flag not set");

   property p_slv_err;
      CE_IN && SG && FETCH_IN.valid && FETCH_IN.resp == RESP_SLVERR && !soft_req
         |=> r_reg.err[ERR_SLV];
   endproperty
   a_slv_err: assert property (p_slv_err) else $error("slave error flag not set");

   property p_dec_err;
      CE_IN && SG && FETCH_IN.valid && FETCH_IN.resp == RESP_DECERR && !soft_req
         |=> r_reg.err[ERR_DEC];
   endproperty
   a_dec_err: assert property (p_dec_err) else $error("decode error flag not set");

   property p_halt;
      CE_IN && new_err && r_reg.state == ST_RUN && !soft_req
         |=> !r_reg.run_stop && !r_reg.stopped && r_reg.state == ST_STOPPING;
   endproperty
   a_halt: assert property (p_halt) else $error("error did not start graceful halt");

   property p_stop_after_idle;
      $rose(r_reg.stopped) |-> $past(ENGINE_IDLE_IN) || $past(soft_req) || !$past(RSTN_IN);
   endproperty
   a_stop_after_idle: assert property (p_stop_after_idle) else $error("stopped before idle");

   property p_capture;
      CE_IN && new_err && r_reg.err == 3'h0 && !soft_req
         |=> r_reg.err != 3'h0 && r_reg.curdesc == $past(FETCH_IN.addr);
   endproperty
   a_capture: assert property (p_capture) else $error("pointer not captured with flag");

   property p_one_addr;
      CE_IN && RSTN_IN && r_reg.err != 3'h0 && !soft_req |=> $stable(r_reg.curdesc);
   endproperty
   a_one_addr: assert property (p_one_addr) else $error("second address captured");

   property p_sticky;
      CE_IN && RSTN_IN && !soft_req |=> (r_reg.err & $past(r_reg.err)) == $past(r_reg.err);
   endproperty
   a_sticky: assert property (p_sticky) else $error("error flag cleared without reset");

   property p_no_sg;
      !SG |-> r_reg.err == 3'h0;
   endproperty
   a_no_sg: assert property (p_no_sg) else $error("flag set without gather support");

   property p_rsvd;
      PSEL_IN && PENABLE_IN && hit(PADDR_IN, OFS_STATUS) |-> !PRDATA_OUT[STS_RSVD_BIT];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved status bit read as one");

   property p_ro_flags;
      CE_IN && wr && hit(PADDR_IN, OFS_STATUS) && !new_err |=> $stable(r_reg.err);
   endproperty
   a_ro_flags: assert property (p_ro_flags) else $error("status write changed flags");

   property p_soft_clear;
      CE_IN && soft_req |=> r_reg.err == 3'h0 && r_reg.stopped;
   endproperty
   a_soft_clear: assert property (p_soft_clear) else $error("soft reset left flags");

   c_err_halt: cover property (new_err ##[1:20] r_reg.stopped);
   c_multi_err: cover property (r_reg.err[ERR_SLV] && r_reg.err[ERR_DEC]);
   c_irq: cover property ($rose(IRQ_OUT));
   c_soft: cover property (soft_req && r_reg.err != 3'h0);
endmodule

/* File: sgel_fetch_slave.sv */
// sgel_fetch_slave: descriptor fetch source facing the gather status block
// assumes the caller starts each send just after a rising edge of clk_in
module sgel_fetch_slave
   import sgel_pkg::*;
(
   input  wire logic             clk_in,
   output sgel_pkg::sgel_fetch_t fetch_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial fetch_out = '0;
   ////////////////////////////////////////////////////////////////////////////
   // one or two results back to back; fields turn over once released
   task automatic send(input logic [31:0] a1, input logic c1, input logic [1:0] r1,
                       input logic [31:0] a2, input logic c2, input logic [1:0] r2, input int n);
      fetch_out <= '{1'b1, a1, c1, r1};
      @(posedge clk_in);
      if (n == 2) begin
         fetch_out <= '{1'b1, a2, c2, r2};
         @(posedge clk_in);
      end
      fetch_out <= '{1'b0, ~a2, ~c2, ~r2};
   endtask
endmodule

/* File: sg_error_status_logic_bench.sv */
// sg_error_status_logic_bench: self-checking bench of the gather status block
// assumes sgel_pkg, sgel_status and sgel_fetch_slave are compiled first
module sg_error_status_logic_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import sgel_pkg::*;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
   $display("Error t=%0t got %h exp %h", $time, a, b); end end
   logic              clk, rstn, psel, penable, pwrite, idle, pready, pslverr, slverr_q;
   logic              run_stop, stopped, irq;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, curdesc, rdq, a1, a2, seed;
   logic [2:0]        errs, errs_simple;
   sgel_fetch_t       fetch;
   int                err_count, check_count, m_err, kb;
   logic [31:0]       cap_q[$];
   ////////////////////////////////////////////////////////////////////////////
   sgel_status sgel_status_inst (.CLK_IN(clk), .RSTN_IN(rstn), .CE_IN(1'b1), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FETCH_IN(fetch),
      .ENGINE_IDLE_IN(idle), .RUN_STOP_OUT(run_stop), .ENGINE_STOPPED_OUT(stopped),
      .ERR_FLAGS_OUT(errs), .CURDESC_OUT(curdesc), .IRQ_OUT(irq));
   // simple mode copy on the same stimulus
   sgel_status #(.GATHER_SUPPORT_PRESENT(0)) sgel_status_inst2 (.CLK_IN(clk), .RSTN_IN(rstn),
      .CE_IN(1'b1), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(), .PREADY_OUT(), .PSLVERR_OUT(), .FETCH_IN(fetch),
      .ENGINE_IDLE_IN(idle), .RUN_STOP_OUT(), .ENGINE_STOPPED_OUT(),
      .ERR_FLAGS_OUT(errs_simple), .CURDESC_OUT(), .IRQ_OUT());
   sgel_fetch_slave sgel_fetch_slave_inst (.clk_in(clk), .fetch_out(fetch));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed & 32'hFFFF_FFC0;
   endfunction
   function automatic logic [1:0] resp_of(int k);
      return (k == 1) ? RESP_SLVERR : (k == 2) ? RESP_DECERR : RESP_OKAY;
   endfunction
   // model: which error lane one fetch result raises, zero if none
   function automatic int flag_of(logic c, logic [1:0] r);
      if (r == RESP_SLVERR) begin
         return 1 << ERR_SLV;
      end
      if (r == RESP_DECERR) begin
         return 1 << ERR_DEC;
      end
      return (c && r == RESP_OKAY) ? (1 << ERR_INT) : 0;
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      rdq = prdata;
      slverr_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle cycle: outputs settle and strobes never retoggle in one step
      @(posedge clk);
      if (i == 16) begin
         err_count++;
         finish_test();
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      finish_test();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rstn, psel, penable, pwrite, idle, paddr, pwdata} = '0;
      seed = 32'd94748;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK(rdq, 32'h0000_0001)
      `CHK({errs, curdesc}, {3'h0, CURDESC_RST})
      apb(1'b0, 8'h3C, 32'h0);
      `CHK({slverr_q, rdq}, {1'b1, 32'h0000_0000})
      $display("test reset values done");
      for (int k = 0; k < 3; k++) begin
         kb = (k + 1) % 3;
         apb(1'b1, OFS_CTRL, 32'h0000_0004);
         `CHK(errs, 3'h0)
         apb(1'b1, OFS_IRQ_MASK, (k == 0) ? 32'h0 : 32'h0000_000F);
         apb(1'b1, OFS_CTRL, 32'h0000_0001);
         a1 = xs();
         a2 = xs();
         sgel_fetch_slave_inst.send(a1, k == 0, resp_of(k), a2, kb == 0, resp_of(kb), 2);
         m_err = flag_of(k == 0, resp_of(k)) | flag_of(kb == 0, resp_of(kb));
         cap_q = {};
         if (flag_of(k == 0, resp_of(k)) != 0) begin
            cap_q.push_back(a1);
         end
         if (flag_of(kb == 0, resp_of(kb)) != 0) begin
            cap_q.push_back(a2);
         end
         @(posedge clk);
         `CHK(errs, m_err[2:0])
         `CHK(curdesc, cap_q[0])
         `CHK({run_stop, stopped}, 2'b00)
         `CHK(errs_simple, 3'h0)
         apb(1'b1, OFS_CTRL, 32'h0000_0001);
         `CHK({run_stop, stopped}, 2'b00)
         idle <= 1'b1;
         repeat (2) @(posedge clk);
         `CHK(stopped, 1'b1)
         idle <= 1'b0;
         apb(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
         apb(1'b0, OFS_STATUS, 32'h0);
         `CHK(rdq, 32'((m_err << 8) | 1))
         `CHK(irq, k != 0)
         apb(1'b0, OFS_IRQ_STATUS, 32'h0);
         `CHK(rdq, 32'((m_err << 1) | 1))
         repeat (2) @(posedge clk);
         `CHK(irq, 1'b0)
         $display("test error pair %0d done", k);
      end
      rstn <= 1'b0;
      @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      `CHK({errs, curdesc}, {3'h0, CURDESC_RST})
      $display("test hard reset done");
      finish_test();
   end
endmodule
